// ===== hdl/scci_interp.v
// Control cell interpreter for an input or output port processor
`timescale 1ns/1ps
`include "scci_defines.vh"

// Contract
// - Opcodes 0 idle, f0 hard reset, 2 clear errors
// - Opcodes 3-6 read entry or its counter
// - Opcodes 7-10 write entry; 9,10 start stamping
// - Opcodes 11,12 write cell counter only
// - Opcode 13 replies only when errors exist
// - Opcodes 14,15 read/write maintenance field by index
// - Route set chosen by pass number 1-3
// - First-row flag copied from cell every pass
// - Route field 32 bits; bits 16, 0 ignored
// - Element path alternates upper and lower halves
// - Reply header from return header field
// - Reset and clear run at first input processor
// - Other opcodes only at recycle points
// - Execute at hop zero; decrement only at recycle points
// - Index carries path id or circuit id
// - Maintenance index decodes all three bytes
// - Info overwritten on read; write verified by readback
// - Software tag passes unchanged
// - Local time captured at operation
// - Return code replaced with outcome when an operation runs; otherwise copied from the cell
// - Codes: success, not processed, bad opcode, bad field
module scci_interp #(
    parameter IS_INPUT_PROC = 1,
    parameter PORT_BITS     = 3,
    parameter PATH_ENTRIES  = 256,
    parameter CIRC_ENTRIES  = 1024,
    parameter MAINT_FIELDS  = 64,
    parameter TIME_BITS     = 32
) (
    // Clock and reset
    input  wire                   clk_sys_i,
    input  wire                   rst_i,
    // Incoming cell fields
    input  wire                   cell_valid_i,
    input  wire                   cell_recycled_i,
    input  wire                   cell_to_link_i,
    input  wire [1:0]             cell_pass_i,
    input  wire [7:0]             cell_opcode_i,
    input  wire [7:0]             cell_hop_i,
    input  wire [23:0]            cell_index_i,
    input  wire [127:0]           cell_info_i,
    input  wire [31:0]            cell_header_i,
    input  wire [31:0]            cell_tag_i,
    input  wire [1:0]             cell_retcode_i,
    input  wire                   cell_row_flag_i,
    input  wire [31:0]            route1_i,
    input  wire [31:0]            route2_i,
    input  wire [31:0]            route3_i,
    input  wire [5:0]             set1_ctl_i,
    input  wire [5:0]             set2_ctl_i,
    input  wire [5:0]             set3_ctl_i,
    // Chip state and access answers
    input  wire                   error_present_i,
    input  wire [127:0]           access_rdata_i,
    input  wire                   access_done_i,
    // Access request to tables and maintenance fields
    output reg                    access_req_o,
    output reg                    access_write_o,
    output reg  [1:0]             access_target_o,
    output reg                    access_counter_o,
    output reg                    access_stamp_o,
    output reg  [23:0]            access_index_o,
    output reg  [127:0]           access_wdata_o,
    // Chip-wide commands
    output reg                    hard_reset_o,
    output reg                    clear_errors_o,
    // Forwarded cell
    output reg                    out_valid_o,
    output reg                    out_reply_o,
    output reg  [7:0]             out_hop_o,
    output reg  [127:0]           out_info_o,
    output reg  [31:0]            out_header_o,
    output reg  [31:0]            out_tag_o,
    output reg  [1:0]             out_retcode_o,
    output reg  [TIME_BITS-1:0]   out_time_o,
    output reg                    out_row_flag_o,
    output reg  [5:0]             out_set_ctl_o,
    output reg  [PORT_BITS-1:0]   out_first_port_o,
    output reg  [PORT_BITS-1:0]   out_second_port_o,
    output reg  [29:0]            out_path_hops_o
);

    // ==========================================================
    // Cell clock
    reg [TIME_BITS-1:0] time_r;
    always @(posedge clk_sys_i) begin
        if (rst_i)
            time_r <= {TIME_BITS{1'b0}};
        else
            time_r <= time_r + {{(TIME_BITS-1){1'b0}}, 1'b1};
    end

    // ==========================================================
    // Opcode decode
    reg       dec_known;
    reg       dec_write;
    reg       dec_counter;
    reg       dec_stamp;
    reg [1:0] dec_target;
    always @* begin
        dec_known   = 1'b1;
        dec_write   = 1'b0;
        dec_counter = 1'b0;
        dec_stamp   = 1'b0;
        dec_target  = `SCCI_TGT_NONE;
        case (cell_opcode_i)
            `SCCI_OPC_IDLE, `SCCI_OPC_ERRORS: dec_target = `SCCI_TGT_NONE;
            `SCCI_OPC_RD_PATH:       dec_target = `SCCI_TGT_PATH;
            `SCCI_OPC_RD_CIRC:       dec_target = `SCCI_TGT_CIRC;
            `SCCI_OPC_RD_PATH_CNT: begin
                dec_target  = `SCCI_TGT_PATH;
                dec_counter = 1'b1;
            end
            `SCCI_OPC_RD_CIRC_CNT: begin
                dec_target  = `SCCI_TGT_CIRC;
                dec_counter = 1'b1;
            end
            `SCCI_OPC_WR_PATH: begin
                dec_target = `SCCI_TGT_PATH;
                dec_write  = 1'b1;
            end
            `SCCI_OPC_WR_CIRC: begin
                dec_target = `SCCI_TGT_CIRC;
                dec_write  = 1'b1;
            end
            `SCCI_OPC_WR_PATH_STAMP: begin
                dec_target = `SCCI_TGT_PATH;
                dec_write  = 1'b1;
                dec_stamp  = 1'b1;
            end
            `SCCI_OPC_WR_CIRC_STAMP: begin
                dec_target = `SCCI_TGT_CIRC;
                dec_write  = 1'b1;
                dec_stamp  = 1'b1;
            end
            `SCCI_OPC_WR_PATH_CNT: begin
                dec_target  = `SCCI_TGT_PATH;
                dec_write   = 1'b1;
                dec_counter = 1'b1;
            end
            `SCCI_OPC_WR_CIRC_CNT: begin
                dec_target  = `SCCI_TGT_CIRC;
                dec_write   = 1'b1;
                dec_counter = 1'b1;
            end
            `SCCI_OPC_RD_MAINT:      dec_target = `SCCI_TGT_MAINT;
            `SCCI_OPC_WR_MAINT: begin
                dec_target = `SCCI_TGT_MAINT;
                dec_write  = 1'b1;
            end
            default:                 dec_known = 1'b0;
        endcase
    end

    // ==========================================================
    // Index range check
    wire [7:0]  idx_vpi = cell_index_i[`SCCI_IDX_VPI_HI:`SCCI_IDX_VPI_LO];
    wire [15:0] idx_vci = cell_index_i[`SCCI_IDX_VCI_HI:`SCCI_IDX_VCI_LO];
    reg         idx_bad;
    always @* begin
        case (dec_target)
            `SCCI_TGT_PATH:  idx_bad = ({24'h0, idx_vpi} >= PATH_ENTRIES);
            `SCCI_TGT_CIRC:  idx_bad = ({16'h0, idx_vci} >= CIRC_ENTRIES);
            `SCCI_TGT_MAINT: idx_bad = ({8'h0, cell_index_i} >= MAINT_FIELDS);
            default:         idx_bad = 1'b0;
        endcase
    end

    // ==========================================================
    // Where the cell may act
    wire is_chipwide = (cell_opcode_i == `SCCI_OPC_HARD_RESET) ||
                       (cell_opcode_i == `SCCI_OPC_CLR_ERR);
    // Input processors meet new cells from the link; chip-wide commands act on first arrival
    wire first_ipp   = (IS_INPUT_PROC != 0) && !cell_recycled_i;
    wire interp_pt   = (IS_INPUT_PROC != 0) ? cell_recycled_i : !cell_to_link_i;
    wire hop_zero    = (cell_hop_i == `SCCI_HOP_ZERO);
    wire do_chipwide = is_chipwide && first_ipp;
    wire do_local    = !is_chipwide && interp_pt && hop_zero;
    // Tables live only in input processors
    wire tbl_at_opp  = (IS_INPUT_PROC == 0) &&
                       ((dec_target == `SCCI_TGT_PATH) || (dec_target == `SCCI_TGT_CIRC));

    // ==========================================================
    // Route set selection
    reg [31:0] route_sel;
    reg [5:0]  ctl_sel;
    always @* begin
        case (cell_pass_i)
            `SCCI_PASS_2: begin
                route_sel = route2_i;
                ctl_sel   = set2_ctl_i;
            end
            `SCCI_PASS_3: begin
                route_sel = route3_i;
                ctl_sel   = set3_ctl_i;
            end
            default: begin
                route_sel = route1_i;
                ctl_sel   = set1_ctl_i;
            end
        endcase
    end

    scci_route_unpack #(
        .PORT_BITS     (PORT_BITS)
    ) u_route (
        .clk_sys_i     (clk_sys_i),
        .rst_i         (rst_i),
        .load_i        (cell_valid_i),
        .route_i       (route_sel),
        .first_port_o  (out_first_port_o),
        .second_port_o (out_second_port_o),
        .path_hops_o   (out_path_hops_o)
    );

    // ==========================================================
    // Operation sequencer
    localparam ST_IDLE   = `SCCI_ST_IDLE;
    localparam ST_EXEC   = `SCCI_ST_EXEC;
    localparam ST_VERIFY = `SCCI_ST_VERIFY;
    localparam ST_DONE   = `SCCI_ST_DONE;
    reg [1:0] state_r;
    reg       errors_only_r;

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r           <= ST_IDLE;
            errors_only_r     <= 1'b0;
            access_req_o      <= 1'b0;
            access_write_o    <= 1'b0;
            access_target_o   <= `SCCI_TGT_NONE;
            access_counter_o  <= 1'b0;
            access_stamp_o    <= 1'b0;
            access_index_o    <= 24'h0;
            access_wdata_o    <= 128'h0;
            hard_reset_o      <= 1'b0;
            clear_errors_o    <= 1'b0;
            out_valid_o       <= 1'b0;
            out_reply_o       <= 1'b0;
            out_hop_o         <= `SCCI_HOP_ZERO;
            out_info_o        <= 128'h0;
            out_header_o      <= 32'h0;
            out_tag_o         <= 32'h0;
            out_retcode_o     <= `SCCI_RET_NOT_PROCESSED;
            out_time_o        <= {TIME_BITS{1'b0}};
            out_row_flag_o    <= 1'b0;
            out_set_ctl_o     <= 6'h0;
        end else begin
            hard_reset_o   <= 1'b0;
            clear_errors_o <= 1'b0;
            out_valid_o    <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cell_valid_i) begin
                        // Copy cell fields; info and return code may be replaced by the operation
                        out_header_o   <= cell_header_i;
                        out_tag_o      <= cell_tag_i;
                        out_row_flag_o <= cell_row_flag_i;
                        out_set_ctl_o  <= ctl_sel;
                        out_info_o     <= cell_info_i;
                        out_retcode_o  <= cell_retcode_i;
                        out_reply_o    <= 1'b0;
                        errors_only_r  <= 1'b0;
                        // Decrement only at interpretable points; wraps 00 to ff
                        out_hop_o      <= interp_pt ? cell_hop_i - `SCCI_HOP_ONE : cell_hop_i;
                        if (do_chipwide) begin
                            hard_reset_o   <= (cell_opcode_i == `SCCI_OPC_HARD_RESET);
                            clear_errors_o <= (cell_opcode_i == `SCCI_OPC_CLR_ERR);
                            out_retcode_o  <= `SCCI_RET_SUCCESS;
                            out_time_o     <= time_r;
                            state_r        <= ST_DONE;
                        end else if (do_local) begin
                            out_time_o <= time_r;
                            if (!dec_known || tbl_at_opp) begin
                                out_retcode_o <= `SCCI_RET_BAD_OPCODE;
                                out_reply_o   <= 1'b1;
                                state_r       <= ST_DONE;
                            end else if (idx_bad) begin
                                out_retcode_o <= `SCCI_RET_BAD_FIELD;
                                out_reply_o   <= 1'b1;
                                state_r       <= ST_DONE;
                            end else if (dec_target == `SCCI_TGT_NONE) begin
                                errors_only_r <= (cell_opcode_i == `SCCI_OPC_ERRORS);
                                out_reply_o   <= (cell_opcode_i != `SCCI_OPC_ERRORS) || error_present_i;
                                out_retcode_o <= `SCCI_RET_SUCCESS;
                                state_r       <= ST_DONE;
                            end else begin
                                access_req_o     <= 1'b1;
                                access_write_o   <= dec_write;
                                access_target_o  <= dec_target;
                                access_counter_o <= dec_counter;
                                access_stamp_o   <= dec_stamp;
                                access_index_o   <= cell_index_i;
                                access_wdata_o   <= cell_info_i;
                                state_r          <= ST_EXEC;
                            end
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_EXEC: begin
                    if (access_done_i) begin
                        if (access_write_o) begin
                            access_write_o <= 1'b0;
                            access_stamp_o <= 1'b0;
                            state_r        <= ST_VERIFY;
                        end else begin
                            access_req_o  <= 1'b0;
                            out_info_o    <= access_rdata_i;
                            out_retcode_o <= `SCCI_RET_SUCCESS;
                            out_reply_o   <= 1'b1;
                            state_r       <= ST_DONE;
                        end
                    end
                end
                ST_VERIFY: begin
                    if (access_done_i) begin
                        access_req_o  <= 1'b0;
                        out_info_o    <= access_rdata_i;
                        out_retcode_o <= `SCCI_RET_SUCCESS;
                        out_reply_o   <= 1'b1;
                        state_r       <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Poll with no error drops the cell instead of forwarding it
                    out_valid_o <= !(errors_only_r && !out_reply_o);
                    state_r     <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule // scci_interp

// ===== hdl/scci_defines.vh
// Constants for the switch control cell interpreter
`ifndef SCCI_DEFINES_VH
`define SCCI_DEFINES_VH

// Operation codes
`define SCCI_OPC_IDLE           8'h00
`define SCCI_OPC_HARD_RESET     8'hf0
`define SCCI_OPC_CLR_ERR        8'h02
`define SCCI_OPC_RD_PATH        8'h03
`define SCCI_OPC_RD_CIRC        8'h04
`define SCCI_OPC_RD_PATH_CNT    8'h05
`define SCCI_OPC_RD_CIRC_CNT    8'h06
`define SCCI_OPC_WR_PATH        8'h07
`define SCCI_OPC_WR_CIRC        8'h08
`define SCCI_OPC_WR_PATH_STAMP  8'h09
`define SCCI_OPC_WR_CIRC_STAMP  8'h0a
`define SCCI_OPC_WR_PATH_CNT    8'h0b
`define SCCI_OPC_WR_CIRC_CNT    8'h0c
`define SCCI_OPC_ERRORS         8'h0d
`define SCCI_OPC_RD_MAINT       8'h0e
`define SCCI_OPC_WR_MAINT       8'h0f

// Return codes
`define SCCI_RET_SUCCESS        2'h0
`define SCCI_RET_NOT_PROCESSED  2'h1
`define SCCI_RET_BAD_OPCODE     2'h2
`define SCCI_RET_BAD_FIELD      2'h3

// Operation target kinds
`define SCCI_TGT_NONE           2'h0
`define SCCI_TGT_PATH           2'h1
`define SCCI_TGT_CIRC           2'h2
`define SCCI_TGT_MAINT          2'h3

// Hop offset
`define SCCI_HOP_ZERO           8'h00
`define SCCI_HOP_ONE            8'h01

// Index field byte positions
`define SCCI_IDX_VPI_HI         23
`define SCCI_IDX_VPI_LO         16
`define SCCI_IDX_VCI_HI         15
`define SCCI_IDX_VCI_LO         0

// Route field positions
`define SCCI_RT_UPPER_MSB       31
`define SCCI_RT_LOWER_MSB       15
`define SCCI_RT_HALF            16
`define SCCI_RT_SLOT            3
`define SCCI_RT_SLOTS           5

// Pass numbers
`define SCCI_PASS_1             2'h1
`define SCCI_PASS_2             2'h2
`define SCCI_PASS_3             2'h3

// Operation states
`define SCCI_ST_IDLE            2'h0
`define SCCI_ST_EXEC            2'h1
`define SCCI_ST_VERIFY          2'h2
`define SCCI_ST_DONE            2'h3

`endif

// ===== hdl/scci_route_unpack.v
// Route word unpacker: port numbers and element paths
`timescale 1ns/1ps

module scci_route_unpack #(
    parameter PORT_BITS = 3
) (
    // Clock and reset
    input  wire                   clk_sys_i,
    input  wire                   rst_i,
    // Route word in
    input  wire                   load_i,
    input  wire [31:0]            route_i,
    // Unpacked outputs
    output reg  [PORT_BITS-1:0]   first_port_o,
    output reg  [PORT_BITS-1:0]   second_port_o,
    output reg  [29:0]            path_hops_o
);

    // ==========================================================
    // Port placement
    // Port numbers sit left-justified in each half; bits 16 and 0
    // never fall inside a slot so they are dropped implicitly
    localparam UP_LSB = `SCCI_RT_UPPER_MSB - PORT_BITS + 1;
    localparam LO_LSB = `SCCI_RT_LOWER_MSB - PORT_BITS + 1;

    // ==========================================================
    // Element path: odd hops from upper half, even from lower
    wire [29:0] hops_nxt;
    genvar g;
    generate
        for (g = 0; g < `SCCI_RT_SLOTS; g = g + 1) begin : g_hop
            assign hops_nxt[6*g+5:6*g+3] =
                route_i[`SCCI_RT_UPPER_MSB-3*g:`SCCI_RT_UPPER_MSB-3*g-2];
            assign hops_nxt[6*g+2:6*g] =
                route_i[`SCCI_RT_LOWER_MSB-3*g:`SCCI_RT_LOWER_MSB-3*g-2];
        end
    endgenerate

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            first_port_o  <= {PORT_BITS{1'b0}};
            second_port_o <= {PORT_BITS{1'b0}};
            path_hops_o   <= 30'h0;
        end else if (load_i) begin
            first_port_o  <= route_i[`SCCI_RT_UPPER_MSB:UP_LSB];
            second_port_o <= route_i[`SCCI_RT_LOWER_MSB:LO_LSB];
            path_hops_o   <= hops_nxt;
        end
    end

endmodule // scci_route_unpack

// ===== testbench/scci_interp_props.sv
// Concurrent checks on the control cell interpreter ports
`timescale 1ns/1ps
module scci_interp_props #(
    parameter PORT_BITS = 3
) (
    // =====
    // Clock, reset and incoming cell
    input wire logic                 clk_sys_i, rst_i, cell_valid_i, cell_recycled_i, cell_row_flag_i,
    input wire logic                 error_present_i, access_done_i,
    input wire logic [1:0]           cell_pass_i,
    input wire logic [7:0]           cell_opcode_i, cell_hop_i,
    input wire logic [31:0]          cell_tag_i, cell_header_i, route1_i, route2_i, route3_i,
    input wire logic [5:0]           set1_ctl_i, set2_ctl_i, set3_ctl_i,
    // Observed outputs
    input wire logic                 access_req_o, access_write_o, hard_reset_o, clear_errors_o,
    input wire logic                 out_valid_o, out_reply_o, out_row_flag_o,
    input wire logic [7:0]           out_hop_o,
    input wire logic [31:0]          out_tag_o, out_header_o,
    input wire logic [5:0]           out_set_ctl_o,
    input wire logic [PORT_BITS-1:0] out_first_port_o, out_second_port_o
);
    logic [31:0] tag_r, hdr_r, rt_r;
    logic [7:0]  hop_r;
    logic [5:0]  set_r;
    logic        row_r;

    // Fields held for the forwarded cell; pass 0 is pass 1
    always @(posedge clk_sys_i) begin
        if (cell_valid_i) begin
            tag_r <= cell_tag_i;
            hdr_r <= cell_header_i;
            hop_r <= cell_hop_i;
            row_r <= cell_row_flag_i;
            set_r <= (cell_pass_i == 2'h2) ? set2_ctl_i : (cell_pass_i == 2'h3) ? set3_ctl_i : set1_ctl_i;
            rt_r  <= (cell_pass_i == 2'h2) ? route2_i : (cell_pass_i == 2'h3) ? route3_i : route1_i;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_tag_pass: assert property (
        out_valid_o |-> out_tag_o == tag_r && out_header_o == hdr_r) else $error("tag or header altered");
    a_row_flag: assert property (
        out_valid_o |-> out_row_flag_o == row_r) else $error("row flag not copied");
    a_set_pick: assert property (
        out_valid_o |-> out_set_ctl_o == set_r) else $error("wrong field set for pass");
    a_port_unpack: assert property (
        cell_valid_i |=> out_first_port_o == rt_r[31-:PORT_BITS] && out_second_port_o == rt_r[15-:PORT_BITS])
        else $error("port numbers misplaced");
    a_hop_count: assert property (
        cell_valid_i && cell_recycled_i && cell_opcode_i == 8'h00 |-> ##2 out_valid_o && out_hop_o == hop_r - 8'h01)
        else $error("hop count not decremented");
    a_skip_fwd: assert property (
        cell_valid_i && cell_recycled_i && cell_hop_i != 8'h00 && cell_opcode_i > 8'h02 && cell_opcode_i < 8'h10
        |-> ##2 out_valid_o && !out_reply_o) else $error("operation done off target");
    a_link_quiet: assert property (
        cell_valid_i && !cell_recycled_i && cell_opcode_i != 8'hf0 && cell_opcode_i != 8'h02
        |=> !access_req_o [*2]) else $error("access on link arrival");
    a_reset_cmd: assert property (
        cell_valid_i && !cell_recycled_i && cell_opcode_i == 8'hf0 |=> hard_reset_o && !clear_errors_o)
        else $error("hard reset not issued");
    a_clear_cmd: assert property (
        cell_valid_i && !cell_recycled_i && cell_opcode_i == 8'h02 |=> clear_errors_o && !hard_reset_o)
        else $error("clear errors not issued");
    a_verify_read: assert property (
        access_req_o && access_write_o && access_done_i |=> access_req_o && !access_write_o)
        else $error("no readback after write");
    a_errors_quiet: assert property (
        cell_valid_i && cell_recycled_i && cell_hop_i == 8'h00 && cell_opcode_i == 8'h0d && !error_present_i
        |=> !out_valid_o [*3]) else $error("poll answered without errors");
endmodule // scci_interp_props

// ===== testbench/scci_store_model.sv
// Storage model answering interpreter accesses
`timescale 1ns/1ps
module scci_store_model (
    // =====
    // Clock, reset and answer delay
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic [3:0]   lag_i,
    // Access request
    input  wire logic         access_req_i,
    input  wire logic         access_write_i,
    input  wire logic [23:0]  access_index_i,
    input  wire logic [127:0] access_wdata_i,
    // Answer
    output logic              access_done_o,
    output logic [127:0]      access_rdata_o
);
    logic [127:0] mem_r [0:15];
    logic [3:0]   cnt_r;

    always @(posedge clk_sys_i) begin
        access_done_o  <= 1'b0;
        // Stale data flips each cycle; only a completed read loads a fresh answer
        access_rdata_o <= rst_i ? 128'h0 : ~access_rdata_o;
        if (rst_i || !access_req_i || access_done_o) begin
            cnt_r <= 4'h0;
        end else if (cnt_r >= lag_i) begin
            access_done_o <= 1'b1;
            cnt_r         <= 4'h0;
            if (access_write_i) begin
                mem_r[access_index_i[19:16] ^ access_index_i[3:0]] <= access_wdata_i;
            end else begin
                access_rdata_o <= mem_r[access_index_i[19:16] ^ access_index_i[3:0]];
            end
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // scci_store_model

// ===== testbench/switch_control_cell_interpreter_test.sv
// Self-checking bench for the control cell interpreter
`timescale 1ns/1ps
module switch_control_cell_interpreter_test;
    // =====
    // Signals
    localparam logic [127:0] INFO = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    logic clk_sys_i = 0, rst_i = 1, cell_valid_i = 0, cell_recycled_i = 0, cell_to_link_i = 0, got;
    logic cell_row_flag_i = 0, error_present_i = 0, access_done_i;
    logic [1:0]   cell_pass_i = 1, cell_retcode_i = 1;
    logic [7:0]   cell_opcode_i = 0, cell_hop_i = 0, out_hop_o;
    logic [23:0]  cell_index_i = 0, access_index_o;
    logic [31:0]  cell_header_i = 0, cell_tag_i = 0, out_header_o, out_tag_o, out_time_o;
    logic [31:0]  route1_i = 32'h2000_4000, route2_i = 32'h6001_a001, route3_i = 32'he000_c000;
    logic [5:0]   set1_ctl_i = 6'h11, set2_ctl_i = 6'h22, set3_ctl_i = 6'h33, out_set_ctl_o;
    logic [127:0] cell_info_i = INFO, access_rdata_i, access_wdata_o, out_info_o;
    logic [3:0]   lag_i = 4'h2;
    logic access_req_o, access_write_o, access_counter_o, access_stamp_o, hard_reset_o, clear_errors_o;
    logic out_valid_o, out_reply_o, out_row_flag_o;
    logic [1:0]   access_target_o, out_retcode_o;
    logic [2:0]   out_first_port_o, out_second_port_o;
    logic [29:0]  out_path_hops_o;
    int err_count = 0, checks_done = 0, n_wr = 0, n_rd = 0, n_hr = 0, n_ce = 0;

    scci_interp #(.IS_INPUT_PROC(1)) dut (.*);
    scci_store_model u_store (.clk_sys_i, .rst_i, .lag_i, .access_req_i(access_req_o),
        .access_write_i(access_write_o), .access_index_i(access_index_o), .access_wdata_i(access_wdata_o),
        .access_done_o(access_done_i), .access_rdata_o(access_rdata_i));

    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (access_done_i === 1'b1) begin
            if (access_write_o) n_wr++;
            else n_rd++;
        end
        if (hard_reset_o === 1'b1) n_hr++;
        if (clear_errors_o === 1'b1) n_ce++;
    end

    task chk(input logic [127:0] g, input logic [127:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Send one cell, await the forwarded one
    task send(input logic [7:0] o, h, input logic r, input logic [1:0] p, input logic [23:0] x);
        @(posedge clk_sys_i) #1;
        {cell_valid_i, cell_opcode_i, cell_hop_i, cell_recycled_i, cell_pass_i, cell_index_i} = {1'b1, o, h, r, p, x};
        cell_tag_i = {o, h, x[15:0]};
        cell_header_i = ~cell_tag_i;
        cell_row_flag_i = h[0];
        @(posedge clk_sys_i) #1;
        cell_valid_i = 0;
        got = 0;
        for (int i = 0; i < 60 && !got; i++) if (out_valid_o === 1'b1) got = 1; else @(posedge clk_sys_i) #1;
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1 rst_i = 0;
        send(8'h00, 8'h00, 1, 2'h1, 24'h0);
        chk(got, 1);
        chk(out_hop_o, 8'hff);
        chk(out_retcode_o, 0);
        chk(out_tag_o, cell_tag_i);
        chk(out_header_o, cell_header_i);
        $display("test idle done");
        send(8'h07, 8'h00, 1, 2'h1, 24'h030000);
        chk(out_info_o, INFO);
        chk(n_wr, 1);
        chk(n_rd, 1);
        lag_i = 4'h9;
        cell_info_i = 128'h0;
        send(8'h03, 8'h00, 1, 2'h1, 24'h030000);
        chk(out_info_o, INFO);
        lag_i = 4'h2;
        $display("test write read done");
        for (int k = 3; k < 16; k++) if (k != 13) begin
            send(k[7:0], 8'h00, 1, 2'h1, 24'h000005);
            chk(out_retcode_o, 0);
        end
        $display("test sweep done");
        send(8'h03, 8'h05, 1, 2'h1, 24'h0);
        chk(out_hop_o, 8'h04);
        chk(out_retcode_o, 1);
        send(8'h03, 8'h00, 0, 2'h1, 24'h0);
        chk(out_hop_o, 8'h00);
        chk(out_retcode_o, 1);
        send(8'h0e, 8'h00, 1, 2'h1, 24'h010005);
        chk(out_retcode_o, 3);
        send(8'h04, 8'h00, 1, 2'h1, 24'h000400);
        chk(out_retcode_o, 3);
        send(8'h20, 8'h00, 1, 2'h1, 24'h0);
        chk(out_retcode_o, 2);
        $display("test faults done");
        send(8'hf0, 8'h07, 0, 2'h1, 24'h0);
        chk(n_hr, 1);
        send(8'h02, 8'h07, 0, 2'h1, 24'h0);
        chk(n_ce, 1);
        send(8'h0d, 8'h00, 1, 2'h1, 24'h0);
        chk(got, 0);
        error_present_i = 1;
        send(8'h0d, 8'h00, 1, 2'h1, 24'h0);
        chk(got, 1);
        $display("test chip done");
        send(8'h00, 8'h03, 1, 2'h2, 24'h0);
        chk(out_set_ctl_o, 6'h22);
        chk(out_first_port_o, 3'h3);
        chk(out_second_port_o, 3'h5);
        send(8'h00, 8'h03, 1, 2'h3, 24'h0);
        chk(out_set_ctl_o, 6'h33);
        $display("test pass sets done");
        report_and_stop;
    end
endmodule // switch_control_cell_interpreter_test

bind scci_interp scci_interp_props #(.PORT_BITS(PORT_BITS)) u_props (.*);
